// ### rtl/vop_pkg.sv
/*
 * Shared constants for the video output stage: register map, field
 * positions, reset values, timing-code words and blanking fills.
 * Assumes a byte-wide register port whose writes arrive already decoded
 * from the serial control bus, one byte per write strobe.
 */
package vop_pkg;

    // ========================================================================
    // register offsets
    localparam logic [7:0] REG_IO_CTL = 8'h05;
    localparam logic [7:0] REG_IO_RANGE = 8'h02;
    localparam logic [7:0] REG_PREGAIN_EN = 8'h3e;
    localparam logic [7:0] REG_PREGAIN = 8'h40;
    localparam logic [7:0] REG_OFS_0 = 8'h77;
    localparam logic [7:0] REG_OFS_1 = 8'h78;
    localparam logic [7:0] REG_OFS_2 = 8'h79;
    localparam logic [7:0] REG_OFS_3 = 8'h7a;
    localparam logic [7:0] REG_CODE_CTL = 8'h7b;
    localparam logic [7:0] REG_DDR_CTL = 8'hc9;
    localparam logic [7:0] REG_MODE = 8'h01;
    localparam logic [7:0] REG_CSC = 8'h03;

    // ========================================================================
    // field positions
    localparam int BIT_SPREAD = 1;
    localparam int BIT_INSERT = 2;
    localparam int BIT_BLANK = 3;
    localparam int BIT_BLANK_YPBPR = 4;
    localparam int BIT_FOLLOW_DE = 0;
    localparam int BIT_POS_SEL = 2;
    localparam int BIT_INV_V = 6;
    localparam int BIT_INV_F = 7;
    localparam int BIT_DDR_SWAP = 2;
    localparam int BIT_DDR_MODE = 3;
    localparam int BIT_PREGAIN_EN = 2;
    localparam int BIT_RANGE = 2;
    localparam int BIT_ALT_SAT = 0;
    localparam int BIT_RGB_OUTPUT_SEL = 0;

    // ========================================================================
    // reset values
    localparam logic [7:0] RST_IO_CTL = 8'h0c;
    localparam logic [7:0] RST_CODE_CTL = 8'h05;
    localparam logic [7:0] RST_DDR_CTL = 8'h04;
    localparam logic [7:0] RST_PREGAIN = 8'h80;
    localparam logic [9:0] OFS_AUTO = 10'h3ff;
    localparam logic [7:0] RST_MODE = 8'h00;

    // ========================================================================
    // timing-code words and blanking values
    localparam logic [9:0] CODE_W0 = 10'h3ff;
    localparam logic [9:0] CODE_W1 = 10'h000;
    localparam logic [9:0] BLANK_RGB = 10'h040;
    localparam logic [9:0] BLANK_CHROMA = 10'h200;
    localparam logic [9:0] OFS_BLACK = 10'h040;
    localparam logic [9:0] OFS_MID = 10'h200;
    localparam logic [9:0] OFS_ZERO = 10'h000;
    localparam logic [9:0] CODE_MAX = 10'h3ff;
    localparam logic [11:0] DEF_SAV_LEAD = 12'h004;

    typedef enum logic [1:0] {
        VOP_TRK_IDLE,
        VOP_TRK_ACTIVE,
        VOP_TRK_BLANK
    } vop_trk_t;

endpackage : vop_pkg

// ### rtl/vop_sync2.sv
/*
 * Two-flop level synchroniser plus a two-sample agreement stage for a multi-bit bus of quasi-static bits.
 * Assumes each bit is a slow level; a word passes only after two matching samples.
 */
`timescale 1ns/1ps
module vop_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r, s2_r, s3_r;

    // ========================================================================
    // first stage read only by the second; the output takes a word only
    // once two settled samples agree, so a torn multi-bit update never
    // reaches the pixel logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            s2_r <= meta_r;
            s3_r <= s2_r;
            q <= (s3_r == s2_r) ? s2_r : q;
        end
    end

endmodule : vop_sync2

// ### rtl/vop_pregain.sv
/*
 * Pregain multiplier with per-channel offset add and clip.
 * Assumes gain and offsets are stable config levels in the pixel domain.
 */
`timescale 1ns/1ps
module vop_pregain (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic gain_en,
    input wire logic [7:0] gain,
    input wire logic [9:0] ofs,
    input wire logic [9:0] din,
    output logic [9:0] dout
);

    logic [9:0] din_r;
    logic [17:0] prod;
    logic [10:0] scaled;
    logic [9:0] gained;
    logic [11:0] sum;
    logic [9:0] dout_nxt;

    // ========================================================================
    // 1.7 fixed point: drop seven fraction bits, clip to ten bits
    assign prod = din_r * gain;
    assign scaled = prod[17:7];
    assign gained = gain_en ? (scaled[10] ? 10'h3ff : scaled[9:0]) : din_r;
    // offset after gain, clipped at the top code
    assign sum = {2'b00, gained} + {2'b00, ofs};
    assign dout_nxt = (sum[11:10] != 2'b00) ? 10'h3ff : sum[9:0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            din_r <= '0;
            dout <= '0;
        end else begin
            // input stage registers the pixel data ahead of the multiplier
            din_r <= din;
            dout <= dout_nxt;
        end
    end

endmodule : vop_pregain

// ### rtl/vop_top.sv
/*
 * Video output stage: offset selection, pregain, blanking and BT.656
 * timing-code insertion onto three 10-bit channels.
 * Assumes a byte register write port on clk and a pixel stream (data,
 * hs, vs, de, field) on the line-locked pixel clock pix_clk.
 */
`timescale 1ns/1ps
module vop_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic pix_clk,
    input wire logic pix_rst_n,
    input wire logic [9:0] in_a,
    input wire logic [9:0] in_b,
    input wire logic [9:0] in_c,
    input wire logic in_hs,
    input wire logic in_vs,
    input wire logic in_de,
    input wire logic in_field,
    output logic [9:0] out_a,
    output logic [9:0] out_b,
    output logic [9:0] out_c,
    output logic out_de
);
    import vop_pkg::*;

    // ========================================================================
    // reset release
    logic rst_s1_r, rst_s2_r, prst_s1_r, prst_s2_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    always_ff @(posedge pix_clk or negedge pix_rst_n) begin
        if (!pix_rst_n) begin
            prst_s1_r <= 1'b0;
            prst_s2_r <= 1'b0;
        end else begin
            prst_s1_r <= 1'b1;
            prst_s2_r <= prst_s1_r;
        end
    end

    // ========================================================================
    // register file
    logic [7:0] io_ctl_r, code_ctl_r, ddr_ctl_r, gain_r, pgen_r;
    logic [7:0] range_r, mode_r, csc_r;
    logic [7:0] b77_r, b78_r, b79_r, b7a_r;
    logic [9:0] ofs_a_r, ofs_b_r, ofs_c_r;
    logic [7:0] last_addr_r;
    logic last_wr_r;
    logic wr_io, wr_code, wr_ddr, wr_gain, wr_pgen, wr_range, wr_mode;
    logic wr_csc, wr77, wr78, wr79, wr7a;
    logic seq_ab, seq_bc, seq_c;

    assign wr_io = reg_wr && reg_addr == REG_IO_CTL;
    assign wr_code = reg_wr && reg_addr == REG_CODE_CTL;
    assign wr_ddr = reg_wr && reg_addr == REG_DDR_CTL;
    assign wr_gain = reg_wr && reg_addr == REG_PREGAIN;
    assign wr_pgen = reg_wr && reg_addr == REG_PREGAIN_EN;
    assign wr_range = reg_wr && reg_addr == REG_IO_RANGE;
    assign wr_mode = reg_wr && reg_addr == REG_MODE;
    assign wr_csc = reg_wr && reg_addr == REG_CSC;
    assign wr77 = reg_wr && reg_addr == REG_OFS_0;
    assign wr78 = reg_wr && reg_addr == REG_OFS_1;
    assign wr79 = reg_wr && reg_addr == REG_OFS_2;
    assign wr7a = reg_wr && reg_addr == REG_OFS_3;
    // second byte commits only if the previous access was its first byte
    assign seq_ab = wr78 && last_wr_r && last_addr_r == REG_OFS_0;
    assign seq_bc = wr79 && last_wr_r && last_addr_r == REG_OFS_1;
    assign seq_c = wr7a && last_wr_r && last_addr_r == REG_OFS_2;

    // staging bytes; the host keeps the write pairs adjacent
    always_ff @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            b77_r <= 8'h3f;
            b78_r <= 8'hff;
            b79_r <= 8'hff;
            b7a_r <= 8'hff;
            last_addr_r <= 8'h00;
            last_wr_r <= 1'b0;
        end else begin
            if (wr77) b77_r <= reg_wdata;
            if (wr78) b78_r <= reg_wdata;
            if (wr79) b79_r <= reg_wdata;
            if (wr7a) b7a_r <= reg_wdata;
            if (reg_wr || reg_rd) begin
                last_addr_r <= reg_addr;
                last_wr_r <= reg_wr;
            end
        end
    end

    // committed offsets, never a half-written value
    always_ff @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            ofs_a_r <= OFS_AUTO;
            ofs_b_r <= OFS_AUTO;
            ofs_c_r <= OFS_AUTO;
        end else begin
            if (seq_ab) ofs_a_r <= {b77_r[5:0], reg_wdata[7:4]};
            if (seq_bc) ofs_b_r <= {b78_r[3:0], reg_wdata[7:2]};
            if (seq_c) ofs_c_r <= {b79_r[1:0], reg_wdata};
        end
    end

    // plain control registers
    always_ff @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            io_ctl_r <= RST_IO_CTL;
            code_ctl_r <= RST_CODE_CTL;
            ddr_ctl_r <= RST_DDR_CTL;
            gain_r <= RST_PREGAIN; // unity gain
            pgen_r <= RST_MODE;
            range_r <= RST_MODE;
            mode_r <= RST_MODE;
            csc_r <= RST_MODE;
        end else begin
            if (wr_io) io_ctl_r <= reg_wdata;
            if (wr_code) code_ctl_r <= reg_wdata;
            if (wr_ddr) ddr_ctl_r <= reg_wdata;
            if (wr_gain) gain_r <= reg_wdata;
            if (wr_pgen) pgen_r <= reg_wdata;
            if (wr_range) range_r <= reg_wdata;
            if (wr_mode) mode_r <= reg_wdata;
            if (wr_csc) csc_r <= reg_wdata;
        end
    end

    // read mux; unmapped reads give zero
    logic [7:0] rd_mux;
    logic [7:0] stat_rd;
    always_comb begin
        case (reg_addr)
            REG_IO_CTL: rd_mux = io_ctl_r;
            REG_CODE_CTL: rd_mux = code_ctl_r;
            REG_DDR_CTL: rd_mux = ddr_ctl_r;
            REG_PREGAIN: rd_mux = gain_r;
            REG_PREGAIN_EN: rd_mux = pgen_r;
            REG_IO_RANGE: rd_mux = range_r;
            REG_MODE: rd_mux = mode_r;
            REG_CSC: rd_mux = csc_r;
            REG_OFS_0: rd_mux = {2'b00, ofs_a_r[9:4]};
            REG_OFS_1: rd_mux = {ofs_a_r[3:0], ofs_b_r[9:6]};
            REG_OFS_2: rd_mux = {ofs_b_r[5:0], ofs_c_r[9:8]};
            REG_OFS_3: rd_mux = ofs_c_r[7:0];
            8'hff: rd_mux = stat_rd;
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) reg_rdata <= 8'h00;
        else if (reg_rd) reg_rdata <= rd_mux;
    end

    // ========================================================================
    // automatic offsets from output colour space and range
    logic rgb_output_sel, lim_rng;
    logic [9:0] auto_a, auto_bc, sel_a, sel_b, sel_c;
    assign rgb_output_sel = csc_r[BIT_RGB_OUTPUT_SEL];
    assign lim_rng = range_r[BIT_RANGE];
    assign auto_a = lim_rng ? OFS_BLACK : OFS_ZERO;
    assign auto_bc = rgb_output_sel ? auto_a : OFS_MID;
    assign sel_a = (ofs_a_r == OFS_AUTO) ? auto_a : ofs_a_r;
    assign sel_b = (ofs_b_r == OFS_AUTO) ? auto_bc : ofs_b_r;
    assign sel_c = (ofs_c_r == OFS_AUTO) ? auto_bc : ofs_c_r;

    // ========================================================================
    // config crossing to pixel domain; quasi-static levels
    localparam int CW = 53;
    logic [CW-1:0] cfg_bus, cfg_p;
    assign cfg_bus = {sel_a, sel_b, sel_c, gain_r, pgen_r[BIT_PREGAIN_EN],
        io_ctl_r[BIT_INSERT], io_ctl_r[BIT_BLANK], io_ctl_r[BIT_SPREAD],
        io_ctl_r[BIT_BLANK_YPBPR], code_ctl_r[BIT_FOLLOW_DE],
        code_ctl_r[BIT_POS_SEL], code_ctl_r[BIT_INV_V],
        code_ctl_r[BIT_INV_F], ddr_ctl_r[BIT_DDR_SWAP],
        ddr_ctl_r[BIT_DDR_MODE], mode_r[3:0]};
    vop_sync2 #(.W(CW)) u_cfg_sync (
        .clk(pix_clk),
        .rst_n(prst_s2_r),
        .d(cfg_bus),
        .q(cfg_p)
    );
    logic [9:0] p_ofs_a, p_ofs_b, p_ofs_c;
    logic [7:0] p_gain;
    logic p_gen, p_ins, p_blk, p_spr, p_ypb, p_fde, p_pos, p_iv, p_if;
    logic p_swp, p_ddr;
    logic [3:0] p_mode;
    assign {p_ofs_a, p_ofs_b, p_ofs_c, p_gain, p_gen, p_ins, p_blk, p_spr,
        p_ypb, p_fde, p_pos, p_iv, p_if, p_swp, p_ddr, p_mode} = cfg_p;

    // pixel inputs are already on pix_clk; sync flags only
    logic hs_r, vs_r, de_r, fld_r, hs_d_r, de_d_r;
    always_ff @(posedge pix_clk or negedge prst_s2_r) begin
        if (!prst_s2_r) begin
            hs_r <= 1'b0;
            vs_r <= 1'b0;
            de_r <= 1'b0;
            fld_r <= 1'b0;
            hs_d_r <= 1'b0;
            de_d_r <= 1'b0;
        end else begin
            hs_r <= in_hs;
            vs_r <= in_vs;
            de_r <= in_de;
            fld_r <= in_field;
            hs_d_r <= hs_r;
            de_d_r <= de_r;
        end
    end

    // ========================================================================
    // pregain then offset and clip, two cycles
    logic [9:0] g_a, g_b, g_c;
    vop_pregain u_pg_a (.clk(pix_clk), .rst_n(prst_s2_r), .gain_en(p_gen),
        .gain(p_gain), .ofs(p_ofs_a), .din(in_a), .dout(g_a));
    vop_pregain u_pg_b (.clk(pix_clk), .rst_n(prst_s2_r), .gain_en(p_gen),
        .gain(p_gain), .ofs(p_ofs_b), .din(in_b), .dout(g_b));
    vop_pregain u_pg_c (.clk(pix_clk), .rst_n(prst_s2_r), .gain_en(p_gen),
        .gain(p_gain), .ofs(p_ofs_c), .din(in_c), .dout(g_c));

    // ========================================================================
    // code trigger: HS edges, or DE edges with default lead
    logic sav_hs, eav_hs, sav_de, eav_de, sav_go, eav_go;
    logic [11:0] lead;
    logic [11:0] cnt_r;
    vop_trk_t trk_r;
    assign sav_hs = hs_d_r && !hs_r;
    assign eav_hs = !hs_d_r && hs_r;
    // default lead grows with mode so wide standards get room
    assign lead = DEF_SAV_LEAD + {8'h00, p_mode};
    assign eav_de = p_fde ? (de_d_r && !de_r) : eav_hs;
    assign sav_de = (trk_r == VOP_TRK_BLANK) && cnt_r == 12'h000;
    assign sav_go = p_pos ? sav_de : sav_hs;
    assign eav_go = p_pos ? eav_de : eav_hs;

    // default-position tracker: count blanking length to place SAV ahead of DE
    logic [11:0] blank_len_r, run_r;
    always_ff @(posedge pix_clk or negedge prst_s2_r) begin
        if (!prst_s2_r) begin
            trk_r <= VOP_TRK_IDLE;
            cnt_r <= 12'h000;
            blank_len_r <= 12'h000;
            run_r <= 12'h000;
        end else begin
            run_r <= (de_d_r && !de_r) ? 12'h000 : run_r + 12'h001;
            case (trk_r)
                VOP_TRK_IDLE: if (eav_de) trk_r <= VOP_TRK_BLANK;
                VOP_TRK_BLANK: begin
                    if (de_r && !de_d_r) begin
                        blank_len_r <= run_r;
                        trk_r <= VOP_TRK_ACTIVE;
                    end
                    cnt_r <= (cnt_r == 12'h000) ? 12'hfff : cnt_r - 12'h001;
                end
                VOP_TRK_ACTIVE: if (eav_de) begin
                    trk_r <= VOP_TRK_BLANK;
                    cnt_r <= (blank_len_r > lead) ? blank_len_r - lead
                        : 12'h001;
                end
                default: trk_r <= VOP_TRK_IDLE;
            endcase
        end
    end
    assign stat_rd = 8'h00;

    // ========================================================================
    // code sequencer and XY word
    logic [1:0] wi_r;
    logic busy_r, is_eav_r;
    logic fb, vb, hb;
    logic [9:0] xy;
    assign fb = fld_r ^ p_if;
    assign vb = vs_r ^ p_iv;
    assign hb = is_eav_r;
    assign xy = {1'b1, fb, vb, hb, vb ^ hb, fb ^ hb, fb ^ vb,
        fb ^ vb ^ hb, 2'b00};
    always_ff @(posedge pix_clk or negedge prst_s2_r) begin
        if (!prst_s2_r) begin
            busy_r <= 1'b0;
            wi_r <= 2'b00;
            is_eav_r <= 1'b0;
        end else if (!busy_r && p_ins && (sav_go || eav_go)) begin
            busy_r <= 1'b1;
            wi_r <= 2'b00;
            is_eav_r <= eav_go;
        end else if (busy_r) begin
            wi_r <= wi_r + 2'b01;
            busy_r <= wi_r != 2'b11;
        end
    end

    // words of the code; spread puts preamble on B/C, tail on A
    logic [9:0] cw_full, cw_bc, cw_a, fill_bc, oa, ob, oc;
    logic blanking;
    assign cw_full = (wi_r == 2'b00) ? CODE_W0
        : (wi_r == 2'b11) ? xy : CODE_W1;
    assign cw_bc = wi_r[0] ? CODE_W1 : CODE_W0;
    assign cw_a = wi_r[0] ? xy : CODE_W1;
    // blanking fill per colour space
    assign fill_bc = p_ypb ? BLANK_CHROMA : BLANK_RGB;
    assign blanking = p_blk && (!de_d_r || vs_r);
    // DDR mode with the swap bit clear exchanges luma and chroma spread code words
    logic swap;
    assign swap = p_ddr && !p_swp;
    always_comb begin
        oa = blanking ? BLANK_RGB : g_a;
        ob = blanking ? fill_bc : g_b;
        oc = blanking ? fill_bc : g_c;
        if (busy_r) begin
            if (p_spr) begin
                oa = swap ? cw_bc : cw_a;
                ob = swap ? cw_a : cw_bc;
                oc = swap ? cw_a : cw_bc;
            end else begin
                oa = cw_full;
                ob = cw_full;
                oc = cw_full;
            end
        end
    end
    always_ff @(posedge pix_clk or negedge prst_s2_r) begin
        if (!prst_s2_r) begin
            out_a <= 10'h000;
            out_b <= 10'h000;
            out_c <= 10'h000;
            out_de <= 1'b0;
        end else begin
            out_a <= oa;
            out_b <= ob;
            out_c <= oc;
            out_de <= de_d_r;
        end
    end

endmodule : vop_top

// ### test/vop_top_sva.sv
/*
 * Port checker for the video output stage: codes, DE delay, readback.
 * Assumes it is bound to vop_top and sees only its ports.
 */
`timescale 1ns/1ps
module vop_top_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic pix_clk,
    input wire logic pix_rst_n,
    input wire logic in_de,
    input wire logic [9:0] out_a,
    input wire logic [9:0] out_b,
    input wire logic [9:0] out_c,
    input wire logic out_de
);
    // ========================================================================
    // code preamble shapes on channel a
    sequence s_pre;
        out_a == 10'h3ff ##1 out_a == 10'h000;
    endsequence
    sequence s_xy;
        s_pre ##1 out_a == 10'h000;
    endsequence
    // ========================================================================
    // pixel side
    chk_code_order:
    assert property (@(posedge pix_clk) disable iff (!pix_rst_n) s_pre |=>
        out_a == 10'h000 ##1 (out_a[9] && out_a[1:0] == 2'b00))
    else $error("code words out of order");
    chk_xy_protect:
    assert property (@(posedge pix_clk) disable iff (!pix_rst_n) s_xy |=>
        out_a[5] == (out_a[7] ^ out_a[6]) && out_a[4] == (out_a[8] ^ out_a[6])
        && out_a[3] == (out_a[8] ^ out_a[7]) && out_a[2] == ^out_a[8:6])
    else $error("status word protection bits wrong");
    chk_code_blank:
    assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
        s_pre |-> !out_de && !$past(out_de))
    else $error("code overlaps active data");
    chk_de_delay:
    assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
        out_de == $past(in_de, 3))
    else $error("data enable not three cycles late");
    chk_quiet_reset:
    assert property (@(posedge pix_clk) disable iff (!rst_n) !pix_rst_n |->
        out_a == 10'h000 && out_b == 10'h000 && out_c == 10'h000 && !out_de)
    else $error("outputs not quiet in pixel reset");
    // ========================================================================
    // register side
    chk_rdata_hold:
    assert property (@(posedge clk) disable iff (!rst_n)
        !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
    chk_unmapped_zero:
    assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == 8'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
    chk_gain_echo:
    assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == 8'h40 ##1 reg_rd && reg_addr == 8'h40
        |=> reg_rdata == $past(reg_wdata, 2))
    else $error("pregain readback differs from write");
endmodule : vop_top_sva

bind vop_top vop_top_sva u_sva (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .pix_clk, .pix_rst_n, .in_de, .out_a, .out_b,
    .out_c, .out_de);

// ### test/vop_sink_model.sv
/*
 * Downstream receiver model: decodes timing codes on channel a and keeps
 * the last active pixels, blanking fill and status words.
 * Assumes codes are unspread and data is sampled on the pixel clock.
 */
`timescale 1ns/1ps
module vop_sink_model (
    input wire logic pix_clk,
    input wire logic [9:0] a,
    input wire logic [9:0] b,
    input wire logic [9:0] c,
    input wire logic de
);
    // ========================================================================
    // capture; history spots the word after 3ff,000,000
    logic [9:0] h1, h2, h3, act_a, act_b, act_c, blank_a, sav_xy, eav_xy;
    int codes = 0;
    wire is_xy = h3 == 10'h3ff && h2 == 10'h000 && h1 == 10'h000;
    always @(posedge pix_clk) begin
        h3 <= h2;
        h2 <= h1;
        h1 <= a;
        if (de) begin
            act_a <= a;
            act_b <= b;
            act_c <= c;
        end else if (is_xy) begin
            codes <= codes + 1;
            if (a[6]) eav_xy <= a;
            else sav_xy <= a;
        end else if (a != 10'h3ff && a != 10'h000) begin
            blank_a <= a;
        end
    end
endmodule : vop_sink_model

// ### test/tb_top.sv
/*
 * Self-checking bench for the video output stage.
 * Assumes vop_top, its checker bind and the receiver model are compiled.
 */
`timescale 1ns/1ps
module tb_top;
    import vop_pkg::*;
    // ========================================================================
    // stimulus, clocks and counters
    logic clk = 0, pix_clk = 0, rst_n = 0, pix_rst_n = 0;
    logic reg_wr = 0, reg_rd = 0, in_hs = 0, in_de = 0, in_field = 1;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [9:0] in_a = 0, in_b = 0, out_a, out_b, out_c;
    logic out_de;
    int fail_count = 0, cmp_count = 0;
    always #2 clk = ~clk;
    // offset start keeps the pixel clock out of phase with clk
    always begin
        if ($time == 0) #1.3;
        #24 pix_clk = ~pix_clk;
    end
    vop_top DUT (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .pix_clk, .pix_rst_n, .in_a, .in_b, .in_c(in_b), .in_hs,
        .in_vs(1'b0), .in_de, .in_field, .out_a, .out_b, .out_c, .out_de);
    vop_sink_model SNK (.pix_clk, .a(out_a), .b(out_b), .c(out_c), .de(out_de));
    // ========================================================================
    // shared tasks
    task automatic summarize;
        if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input string n, input logic [9:0] e, logic [9:0] s);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk
    // write strobe stays up so writes and a read can run back to back
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1;
        reg_addr = ad;
        reg_wdata = d;
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(negedge clk);
        reg_wr = 0;
        reg_rd = 1;
        reg_addr = ad;
        @(negedge clk);
        reg_rd = 0;
        chk("reg_rdata", {2'b00, e}, {2'b00, reg_rdata});
    endtask : rd
    task automatic idle;
        @(negedge clk);
        reg_wr = 0;
    endtask : idle
    // three lines: 12 active pixels, then 20 blanking with a sync pulse
    task automatic run(input logic [9:0] va);
        for (int i = 0; i < 96; i++) begin
            @(negedge pix_clk);
            in_de = i % 32 < 12;
            in_hs = i % 32 >= 16 && i % 32 < 22;
            in_a = in_de ? va : 10'h155;
            in_b = in_de ? 10'h080 : 10'h155;
        end
    endtask : run
    // ========================================================================
    // scenarios
    task automatic t_regs;
        rd(REG_IO_CTL, RST_IO_CTL);
        rd(REG_CODE_CTL, RST_CODE_CTL);
        rd(REG_DDR_CTL, RST_DDR_CTL);
        rd(REG_PREGAIN, RST_PREGAIN);
        rd(8'h10, 8'h00);
    endtask : t_regs
    task automatic t_auto;
        run(10'h100);
        chk("out_a", 10'h100, SNK.act_a);
        chk("out_b", 10'h280, SNK.act_b);
        chk("out_c", 10'h280, SNK.act_c);
        chk("sav", 10'h31c, SNK.sav_xy);
        chk("eav", 10'h368, SNK.eav_xy);
        chk("fill", BLANK_RGB, SNK.blank_a);
    endtask : t_auto
    task automatic t_invert;
        int n;
        wr(REG_CODE_CTL, RST_CODE_CTL | 8'hc0);
        idle;
        @(negedge pix_clk);
        pix_rst_n = 0;
        repeat (2) @(negedge pix_clk);
        pix_rst_n = 1;
        repeat (4) @(negedge pix_clk);
        run(10'h100);
        chk("sav", 10'h2ac, SNK.sav_xy);
        chk("eav", 10'h2d8, SNK.eav_xy);
        wr(REG_IO_CTL, 8'h08);
        idle;
        // let the last code in flight drain and the new setting cross
        repeat (12) @(negedge pix_clk);
        n = SNK.codes;
        run(10'h100);
        chk("codes", 10'h000, 10'(SNK.codes - n));
    endtask : t_invert
    task automatic t_offset;
        wr(REG_OFS_0, 8'h01);
        wr(REG_OFS_1, 8'h00);
        idle;
        run(10'h100);
        chk("out_a", 10'h110, SNK.act_a);
        chk("out_b", 10'h280, SNK.act_b);
        wr(REG_OFS_0, 8'h02);
        rd(8'h10, 8'h00);
        wr(REG_OFS_1, 8'h00);
        wr(REG_OFS_2, 8'h00);
        wr(REG_OFS_3, 8'h05);
        idle;
        run(10'h100);
        chk("out_a", 10'h110, SNK.act_a);
        chk("out_b", 10'h080, SNK.act_b);
        chk("out_c", 10'h085, SNK.act_c);
    endtask : t_offset
    task automatic t_gain;
        wr(REG_PREGAIN_EN, 8'h04);
        wr(REG_PREGAIN, 8'h40);
        rd(REG_PREGAIN, 8'h40);
        run(10'h100);
        chk("out_a", 10'h090, SNK.act_a);
        wr(REG_PREGAIN, 8'hff);
        idle;
        run(10'h100);
        chk("out_a", 10'h20e, SNK.act_a);
        run(10'h300);
        chk("out_a", CODE_MAX, SNK.act_a);
    endtask : t_gain
    // ========================================================================
    // main sequence and hang guard
    initial begin
        repeat (2) @(negedge pix_clk);
        rst_n = 1;
        pix_rst_n = 1;
        repeat (4) @(negedge pix_clk);
        t_regs;
        t_auto;
        t_invert;
        t_offset;
        t_gain;
        summarize;
    end
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        summarize;
    end
endmodule : tb_top
